// ---- rtl/sar_pkg.sv ----
package sar_pkg;

   // =========================================================
   // Result format
   // =========================================================
   localparam int              RES_BITS     = 13;
   localparam int              FIFO_DEPTH   = 8;
   localparam logic [3:0]      STEP_FIRST   = 4'h0;
   localparam logic [3:0]      STEP_LAST    = 4'(RES_BITS - 1);
   localparam logic [12:0]     CODE_ZERO    = 13'h0000;
   // Full-scale code limits in two's complement.
   localparam logic [12:0]     CODE_MIN     = 13'h1000;
   localparam logic [12:0]     CODE_MAX     = 13'h0fff;

   // =========================================================
   // Scale
   // =========================================================
   localparam int              REF_MV       = 4096;
   localparam int              LSB_UV       = (2 * REF_MV * 1000) / (2 ** RES_BITS);

   // =========================================================
   // Timing
   // =========================================================
   localparam int              CONV_RATE_SPS = 5_000_000;
   localparam int              CLK_PERIOD_NS = 8;
   localparam int              CYCLE_NS      = 1_000_000_000 / CONV_RATE_SPS;
   localparam int              CYCLE_CLKS    = (CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0]      CYCLE_CLKS_W  = 8'(CYCLE_CLKS);
   localparam logic [7:0]      CNT_ZERO      = 8'h00;
   localparam logic [7:0]      CNT_ONE       = 8'h01;
   localparam logic [7:0]      CNT_MAX       = 8'hff;

   // =========================================================
   // Sequencer states
   // =========================================================
   typedef enum logic [1:0] {
      ST_ACQUIRE,
      ST_CONVERT,
      ST_HOLD
   } sar_state_t;

endpackage : sar_pkg

// ---- rtl/sar_fifo.sv ----
`timescale 1ns/100ps

module sar_fifo #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             reset_i,
   // Filling side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Draining side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);

   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
   localparam logic [AW:0] CNT_ONE  = (AW+1)'(1);
   localparam logic [AW-1:0] PTR_ONE = AW'(1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_r, wr_ptr_nxt;
   logic [AW-1:0]    rd_ptr_r, rd_ptr_nxt;
   logic [AW:0]      count_r,  count_nxt;
   logic             valid_r,  valid_nxt;
   logic [WIDTH-1:0] data_r,   data_nxt;
   logic             push;
   logic             pop;

   assign in_ready_o  = (count_r != CNT_FULL);
   assign out_valid_o = valid_r;
   assign out_data_o  = data_r;

   // =========================================================
   // Pointers and output register
   // =========================================================
   always_comb begin
      push       = in_valid_i && (count_r != CNT_FULL);
      pop        = (!valid_r || out_ready_i) && (count_r != '0);
      wr_ptr_nxt = push ? wr_ptr_r + PTR_ONE : wr_ptr_r;
      rd_ptr_nxt = pop ? rd_ptr_r + PTR_ONE : rd_ptr_r;
      count_nxt  = count_r;
      if (push && !pop) begin
         count_nxt = count_r + CNT_ONE;
      end else if (pop && !push) begin
         count_nxt = count_r - CNT_ONE;
      end
      valid_nxt = valid_r && !out_ready_i;
      data_nxt  = data_r;
      if (pop) begin
         valid_nxt = 1'b1;
         data_nxt  = mem[rd_ptr_r];
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
         valid_r  <= 1'b0;
         data_r   <= '0;
      end else begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         count_r  <= count_nxt;
         valid_r  <= valid_nxt;
         data_r   <= data_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data_i;
      end
   end

endmodule : sar_fifo

// ---- rtl/sar_sequencer.sv ----
`timescale 1ns/100ps

module sar_sequencer
   import sar_pkg::*;
(
   // Clock and reset
   input  wire logic                CLK_I,
   input  wire logic                RESET_I,
   // Host link
   input  wire logic                CONVERT_START_N_I,
   input  wire logic                SERIAL_CLK_I,
   output logic                     SERIAL_RESULT_OUT_O,
   output logic                     SERIAL_RESULT_OE_N_O,
   // Analog core
   input  wire logic                COMPARATOR_I,
   output logic                     SAMPLE_EN_O,
   output logic [RES_BITS-1:0]      CAPACITIVE_APPROX_DAC_O
);

   // =========================================================
   // Declarations
   // =========================================================
   logic                cnv_s1_r, cnv_s2_r, cnv_d_r;
   logic                sck_s1_r, sck_s2_r, sck_d_r;
   logic                cmp_s1_r, cmp_s2_r;
   logic                cnv_fall, cnv_rise, sck_fall;

   sar_state_t          state_r,    state_nxt;
   logic [3:0]          step_r,     step_nxt;
   logic [RES_BITS-1:0] sar_r,      sar_nxt;
   logic                sample_r,   sample_nxt;
   logic                res_vld_r,  res_vld_nxt;
   logic [RES_BITS-1:0] res_data_r, res_data_nxt;

   logic [RES_BITS-1:0] shift_r,    shift_nxt;
   logic                sdo_r,      sdo_nxt;
   logic                oe_n_r,     oe_n_nxt;
   logic                fifo_pop;

   logic                fifo_in_ready;
   logic                fifo_out_valid;
   logic [RES_BITS-1:0] fifo_out_data;

   logic [7:0]          cyc_cnt_r,  cyc_cnt_nxt;

   // One-hot weight of the bit tried in a given step, MSB first.
   function automatic logic [RES_BITS-1:0] trial_bit(input logic [3:0] step);
      logic [RES_BITS-1:0] w;
      w = '0;
      w[STEP_LAST - step] = 1'b1;
      return w;
   endfunction : trial_bit

   // =========================================================
   // Pin synchronisers and edge detection
   // =========================================================
   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         cnv_s1_r <= 1'b1;
         cnv_s2_r <= 1'b1;
         cnv_d_r  <= 1'b1;
         sck_s1_r <= 1'b0;
         sck_s2_r <= 1'b0;
         sck_d_r  <= 1'b0;
         cmp_s1_r <= 1'b0;
         cmp_s2_r <= 1'b0;
      end else begin
         cnv_s1_r <= CONVERT_START_N_I;
         cnv_s2_r <= cnv_s1_r;
         cnv_d_r  <= cnv_s2_r;
         sck_s1_r <= SERIAL_CLK_I;
         sck_s2_r <= sck_s1_r;
         sck_d_r  <= sck_s2_r;
         cmp_s1_r <= COMPARATOR_I;
         cmp_s2_r <= cmp_s1_r;
      end
   end

   assign cnv_fall = cnv_d_r && !cnv_s2_r;
   assign cnv_rise = !cnv_d_r && cnv_s2_r;
   assign sck_fall = sck_d_r && !sck_s2_r;

   // =========================================================
   // Successive approximation sequencer
   // =========================================================
   // The comparator is high when the held sample is at or above the trial level.
   // The DAC code is offset binary; flipping its top bit gives two's complement.
   // The same steps serve every input style; only the analog span differs.
   always_comb begin
      state_nxt    = state_r;
      step_nxt     = step_r;
      sar_nxt      = sar_r;
      sample_nxt   = sample_r;
      res_vld_nxt  = res_vld_r && !fifo_in_ready;
      res_data_nxt = res_data_r;
      unique case (state_r)
         ST_ACQUIRE: begin
            if (cnv_fall) begin
               state_nxt  = ST_CONVERT;
               step_nxt   = STEP_FIRST;
               sar_nxt    = trial_bit(STEP_FIRST);
               sample_nxt = 1'b0;
            end
         end
         ST_CONVERT: begin
            if (cnv_rise) begin
               // An early rise abandons the partial code and resumes sampling.
               state_nxt  = ST_ACQUIRE;
               sample_nxt = 1'b1;
            end else if (sck_fall && !(step_r == STEP_LAST && res_vld_r)) begin
               sar_nxt[STEP_LAST - step_r] = cmp_s2_r;
               if (step_r == STEP_LAST) begin
                  // Codes beyond a reduced span are kept as they are.
                  res_data_nxt = {~sar_nxt[RES_BITS-1], sar_nxt[RES_BITS-2:0]};
                  res_vld_nxt  = 1'b1;
                  state_nxt    = ST_HOLD;
               end else begin
                  step_nxt = step_r + 4'h1;
                  sar_nxt  = sar_nxt | trial_bit(step_r + 4'h1);
               end
            end
         end
         ST_HOLD: begin
            if (cnv_rise) begin
               state_nxt  = ST_ACQUIRE;
               sample_nxt = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         state_r    <= ST_ACQUIRE;
         step_r     <= STEP_FIRST;
         sar_r      <= CODE_ZERO;
         sample_r   <= 1'b1;
         res_vld_r  <= 1'b0;
         res_data_r <= CODE_ZERO;
      end else begin
         state_r    <= state_nxt;
         step_r     <= step_nxt;
         sar_r      <= sar_nxt;
         sample_r   <= sample_nxt;
         res_vld_r  <= res_vld_nxt;
         res_data_r <= res_data_nxt;
      end
   end

   // One code step is twice the reference over 2^RES_BITS.
   assign CAPACITIVE_APPROX_DAC_O = sar_r;
   assign SAMPLE_EN_O             = sample_r;

   // =========================================================
   // Result buffer
   // =========================================================
   // A full buffer holds the last decision until a word drains.
   sar_fifo #(
      .WIDTH (RES_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (CLK_I),
      .reset_i     (RESET_I),
      .in_valid_i  (res_vld_r),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (res_data_r),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (fifo_pop),
      .out_data_o  (fifo_out_data)
   );

   // =========================================================
   // Serial output
   // =========================================================
   // The word shifted in this cycle is the previous sample's result.
   // With no stored result the line shifts zeros.
   always_comb begin
      shift_nxt = shift_r;
      sdo_nxt   = sdo_r;
      oe_n_nxt  = oe_n_r;
      fifo_pop  = 1'b0;
      if (state_r == ST_ACQUIRE) begin
         if (cnv_fall) begin
            fifo_pop  = 1'b1;
            shift_nxt = fifo_out_valid ? fifo_out_data : CODE_ZERO;
            sdo_nxt   = shift_nxt[RES_BITS-1];
            oe_n_nxt  = 1'b0;
         end
      end else if (cnv_rise) begin
         oe_n_nxt = 1'b1;
      end else if (sck_fall) begin
         shift_nxt = {shift_r[RES_BITS-2:0], 1'b0};
         sdo_nxt   = shift_r[RES_BITS-2];
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         shift_r <= CODE_ZERO;
         sdo_r   <= 1'b0;
         oe_n_r  <= 1'b1;
      end else begin
         shift_r <= shift_nxt;
         sdo_r   <= sdo_nxt;
         oe_n_r  <= oe_n_nxt;
      end
   end

   assign SERIAL_RESULT_OUT_O  = sdo_r;
   assign SERIAL_RESULT_OE_N_O = oe_n_r;

   // =========================================================
   // Checks
   // =========================================================
   // Clocks since the last convert fall, saturating.
   always_comb begin
      cyc_cnt_nxt = cyc_cnt_r;
      if (cnv_fall) begin
         cyc_cnt_nxt = CNT_ONE;
      end else if (cyc_cnt_r != CNT_MAX) begin
         cyc_cnt_nxt = cyc_cnt_r + CNT_ONE;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         cyc_cnt_r <= CNT_ZERO;
      end else begin
         cyc_cnt_r <= cyc_cnt_nxt;
      end
   end

   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (RESET_I);

   a_start_convert: assert property (
      (state_r == ST_ACQUIRE && cnv_fall) |=> (state_r == ST_CONVERT && !sample_r && step_r == STEP_FIRST))
      else $error("Convert fall did not start a conversion.");

   a_release_sample: assert property (
      (state_r != ST_ACQUIRE && cnv_rise) |=> (sample_r && oe_n_r) ##1 (state_r == ST_ACQUIRE))
      else $error("Convert rise did not return to sampling.");

   a_step_advance: assert property (
      (state_r == ST_CONVERT && sck_fall && !cnv_rise && step_r != STEP_LAST)
      |=> (step_r == $past(step_r) + 4'h1))
      else $error("Serial clock fall did not advance the step.");

   a_dac_steady: assert property (
      (state_r == ST_CONVERT && !sck_fall && !cnv_rise) |=> $stable(sar_r))
      else $error("DAC code changed without a serial clock fall.");

   a_sign_bit: assert property (
      $rose(res_vld_r) |-> (res_data_r[RES_BITS-1] == !sar_r[RES_BITS-1] && $past(step_r) == STEP_LAST))
      else $error("Result sign bit does not match the decided code.");

   a_msb_first: assert property (
      (state_r == ST_ACQUIRE && cnv_fall && fifo_out_valid)
      |=> (!oe_n_r && sdo_r == $past(fifo_out_data[RES_BITS-1])))
      else $error("Most significant bit not presented at convert fall.");

   a_shift_next: assert property (
      (state_r != ST_ACQUIRE && sck_fall && !cnv_rise) |=> (sdo_r == $past(shift_r[RES_BITS-2])))
      else $error("Serial output did not shift on clock fall.");

   a_result_queued: assert property (
      (res_vld_r && fifo_in_ready) |=> !res_vld_r)
      else $error("Finished result was not taken by the buffer.");

   // One clock after a convert fall the first trial weight stands on the DAC.
   a_first_trial: assert property (
      (state_r == ST_CONVERT && cyc_cnt_r == CNT_ONE) |-> (step_r == STEP_FIRST && sar_r == trial_bit(STEP_FIRST)))
      else $error("First trial code not set after convert fall.");

   // Serial clock falls while sampling are ignored and the pin stays released.
   a_idle_quiet: assert property (
      (state_r == ST_ACQUIRE && !cnv_fall) |=> (sample_r && oe_n_r && $stable(sdo_r)))
      else $error("Output or sampling changed while convert was high.");

   // Falls beyond the thirteenth shift zeros while the pin is still driven.
   a_zero_fill: assert property (
      (state_r == ST_HOLD && sck_fall && !cnv_rise) |=> (!sdo_r && !oe_n_r))
      else $error("Extra serial clock fall did not shift a zero.");

endmodule : sar_sequencer

// ---- dv/sar_host_model.sv ----
`timescale 1ns/100ps

module sar_host_model (
   // Clock
   input  wire logic clk_i,
   // Link to the converter
   output logic      convert_start_n_o,
   output logic      serial_clk_o,
   input  wire logic serial_result_out_i,
   input  wire logic serial_result_oe_n_i
);

   // ==========================================================
   // Serial line level
   // ==========================================================
   logic line_last_r;
   logic line_lvl;

   // A released line shows the inverse of what was last driven, so stale data never passes.
   always @(posedge clk_i) if (!serial_result_oe_n_i) line_last_r <= serial_result_out_i;
   assign line_lvl = serial_result_oe_n_i ? ~line_last_r : serial_result_out_i;

   initial begin
      convert_start_n_o = 1'b1;
      serial_clk_o      = 1'b0;
      line_last_r       = 1'b0;
   end

   // ==========================================================
   // Link tasks
   // ==========================================================
   // Sets the convert level and holds it for six clocks.
   task automatic convert_start_n(input logic lvl);
      convert_start_n_o <= lvl;
      repeat (6) @(posedge clk_i);
   endtask : convert_start_n

   // Gives n serial clock pulses, 80 ns high in a 160 ns period, and samples the line before each falling edge.
   task automatic shift(input int n, output logic [15:0] bits);
      bits = 16'h0000;
      for (int i = 0; i < n; i++) begin
         serial_clk_o <= 1'b1;
         repeat (10) @(posedge clk_i);
         bits = {bits[14:0], line_lvl};
         serial_clk_o <= 1'b0;
         repeat (10) @(posedge clk_i);
      end
   endtask : shift

endmodule : sar_host_model

// ---- dv/tb.sv ----
`timescale 1ns/100ps

module tb
   import sar_pkg::*;
;
   // ==========================================================
   // Signals
   // ==========================================================
   logic                clk;
   logic                rst;
   logic                cnv_n;
   logic                sclk;
   logic                serial_result_out;
   logic                sdo_oe_n;
   logic                comp_r;
   logic                samp_en;
   logic [RES_BITS-1:0] dac;
   logic [RES_BITS-1:0] analog_r;
   logic [RES_BITS-1:0] held_r;
   logic [RES_BITS-1:0] exp_prev;
   int                  err_total;
   int                  n_tests;

   sar_sequencer DUT (.CLK_I(clk), .RESET_I(rst), .CONVERT_START_N_I(cnv_n), .SERIAL_CLK_I(sclk),
      .SERIAL_RESULT_OUT_O(serial_result_out), .SERIAL_RESULT_OE_N_O(sdo_oe_n), .COMPARATOR_I(comp_r),
      .SAMPLE_EN_O(samp_en), .CAPACITIVE_APPROX_DAC_O(dac));
   sar_host_model HOST (.clk_i(clk), .convert_start_n_o(cnv_n), .serial_clk_o(sclk),
      .serial_result_out_i(serial_result_out), .serial_result_oe_n_i(sdo_oe_n));

   // ==========================================================
   // Clock and analog core
   // ==========================================================
   always #4 clk = ~clk;

   // The sample tracks the input while the switch is closed; the comparator weighs it against the trial code.
   always @(posedge clk) begin
      if (samp_en) held_r <= analog_r;
      comp_r <= (held_r >= dac);
   end

   // ==========================================================
   // Checking and closing
   // ==========================================================
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic conclude();
      if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude

   // One conversion of v; the word read out belongs to the conversion before.
   task automatic conv_chk(input logic [12:0] v, input logic [12:0] code, input bit do_chk);
      logic [15:0] bits;
      analog_r <= v;
      HOST.convert_start_n(1'b0);
      check({13'h0000, samp_en, sdo_oe_n, 1'b0}, 16'h0000);
      check({3'h0, dac}, 16'h1000);
      HOST.shift(13, bits);
      HOST.convert_start_n(1'b1);
      check({14'h0000, samp_en, sdo_oe_n}, 16'h0003);
      if (do_chk) check({{3{bits[12]}}, bits[12:0]}, {{3{exp_prev[12]}}, exp_prev});
      exp_prev = code;
   endtask : conv_chk

   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_reset();
      check({13'h0000, serial_result_out, sdo_oe_n, samp_en}, 16'h0003);
      check({3'h0, dac}, 16'h0000);
   endtask : t_reset

   // Full-scale and half-scale inputs of every input style, read out back to back.
   task automatic t_codes();
      logic [12:0] vin [6]  = '{13'h1fff, 13'h0000, 13'h0800, 13'h17ff, 13'h1000, 13'h0a5c};
      logic [12:0] vexp [6] = '{13'h0fff, 13'h1000, 13'h1800, 13'h07ff, 13'h0000, 13'h1a5c};
      conv_chk(13'h1234, 13'h0234, 1'b0);
      for (int i = 0; i < 6; i++) conv_chk(vin[i], vexp[i], 1'b1);
      conv_chk(13'h0fff, 13'h1fff, 1'b1);
   endtask : t_codes

   // Fifteen pulses in one frame: the two extra bits are zero.
   task automatic t_extra();
      logic [15:0] bits;
      analog_r <= 13'h0555;
      HOST.convert_start_n(1'b0);
      HOST.shift(15, bits);
      HOST.convert_start_n(1'b1);
      check({1'b0, bits[14:2], bits[1:0]}, {1'b0, exp_prev, 2'b00});
      exp_prev = 13'h1555;
      conv_chk(13'h1aaa, 13'h0aaa, 1'b1);
   endtask : t_extra

   // Pulses while convert is high are ignored.
   task automatic t_idle_pulses();
      logic [15:0] bits;
      HOST.shift(3, bits);
      conv_chk(13'h0321, 13'h1321, 1'b1);
   endtask : t_idle_pulses

   // Convert rises after five pulses: the pin is released and sampling resumes.
   task automatic t_abort();
      logic [15:0] bits;
      HOST.convert_start_n(1'b0);
      HOST.shift(5, bits);
      HOST.convert_start_n(1'b1);
      check({14'h0000, samp_en, sdo_oe_n}, 16'h0003);
      conv_chk(13'h0c00, 13'h1c00, 1'b0);
      conv_chk(13'h1e01, 13'h0e01, 1'b1);
   endtask : t_abort

   // A reset in mid-run empties the result buffer, so the first word read after it is zero.
   task automatic t_fifo();
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      check({13'h0000, serial_result_out, sdo_oe_n, samp_en}, 16'h0003);
      check({3'h0, dac}, 16'h0000);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      exp_prev = CODE_ZERO;
      conv_chk(13'h0abc, 13'h1abc, 1'b1);
      conv_chk(13'h1abc, 13'h0abc, 1'b1);
   endtask : t_fifo

   // ==========================================================
   // Main sequence and watchdog
   // ==========================================================
   initial begin
      clk       = 1'b0;
      rst       = 1'b1;
      analog_r  = 13'h0000;
      held_r    = 13'h0000;
      comp_r    = 1'b0;
      exp_prev  = 13'h0000;
      err_total = 0;
      n_tests   = 0;
      repeat (8) @(posedge clk);
      t_reset();
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_codes();
      t_extra();
      t_idle_pulses();
      t_abort();
      t_fifo();
      conclude();
   end

   initial begin
      #200000;
      err_total++;
      conclude();
   end

endmodule : tb
